// ==== src/tcsp_pkg.sv ====
// Constants shared by the timer/counter and its prescaler.
// Assumes a 25 MHz core clock in which one clock period is one oscillator period.
package tcsp_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TOSC_NS = 40;
  localparam int TOSC_CLKS = (TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASES_PER_INSTR = 4;
  localparam int WRITE_INHIBIT_INSTR = 2;
  localparam int WRITE_INHIBIT_CLKS = WRITE_INHIBIT_INSTR * PHASES_PER_INSTR * TOSC_CLKS;
  localparam int ROLLOVER_DELAY_TOSC = 3;
  localparam int ROLLOVER_DELAY_CLKS = ROLLOVER_DELAY_TOSC * TOSC_CLKS;

  // Phase numbering inside one instruction cycle (Q1..Q4 -> 0..3)
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Register byte offsets on the bus
  localparam logic [3:0] OFF_COUNT = 4'h0;
  localparam logic [3:0] OFF_OPTION = 4'h4;
  localparam logic [3:0] OFF_INTCTL = 4'h8;

  // Option register fields
  localparam int OPT_CSS_BIT = 5;
  localparam int OPT_SES_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_W = 6;

  // Interrupt control register fields
  localparam int ICR_IEN_BIT = 5;
  localparam int ICR_FLAG_BIT = 2;

  // Reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [OPT_W-1:0] RST_OPTION = 6'h3f;
  localparam logic RST_IEN = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_PSC = 8'h00;
endpackage

// ==== src/tcsp_psc_if.sv ====
// Link between the timer core and the shared 8-bit prescaler.
// Assumes both ends sit on the same clock and reset.
`timescale 1ns/1ps
interface tcsp_psc_if;
  logic ce;
  logic tick;
  logic clear;
  logic [2:0] ratio;
  logic level;
  logic rise;
  logic [7:0] count;

  modport core (output ce, output tick, output clear, output ratio, input level, input rise, input count);
  modport psc (input ce, input tick, input clear, input ratio, output level, output rise, output count);
endinterface

// ==== src/tcsp_prescaler.sv ====
// Shared 8-bit prescaler: counts ticks, output is the count bit picked by the ratio.
// Assumes ticks and clear come from logic on the same clock.
`timescale 1ns/1ps
module tcsp_prescaler (
  input wire logic clock_i,
  input wire logic nrst_i,
  tcsp_psc_if.psc bus
);
  typedef struct packed {
    logic [7:0] cnt;
  } tcsp_psc_state_t;

  tcsp_psc_state_t st;
  tcsp_psc_state_t next_st;
  logic [7:0] inc;

  // Bit n of the count rises once per 2^(n+1) ticks and is high half the time
  function automatic logic bit_rises(input logic [7:0] cur, input logic [7:0] nxt, input logic [2:0] n);
    bit_rises = nxt[n] && !cur[n];
  endfunction

  always_comb begin
    next_st = st;
    inc = st.cnt + 8'h01;
    bus.rise = 1'b0;
    if (bus.clear) begin
      next_st.cnt = tcsp_pkg::RST_PSC;
    end else if (bus.tick) begin
      next_st.cnt = inc;
      bus.rise = bit_rises(st.cnt, inc, bus.ratio);
    end
    bus.level = st.cnt[bus.ratio];
    bus.count = st.cnt;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.cnt <= tcsp_pkg::RST_PSC;
    end else if (bus.ce) begin
      st <= next_st;
    end
  end
endmodule

// ==== src/tcsp_top.sv ====
// 8-bit timer/counter with shared prescaler, registers on a classic Wishbone slave.
// Assumes sleep_i, wdt_tick_i and wdt_clear_i come from logic on clock_i.
//
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module tcsp_top (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_count_input_i,
  input wire logic sleep_i,
  input wire logic wdt_tick_i,
  input wire logic wdt_clear_i,
  output logic wdt_tick_o,
  output logic overflow_irq_o
);
  typedef struct packed {
    logic [1:0] phase;
    logic [7:0] count;
    logic [tcsp_pkg::OPT_W-1:0] option;
    logic ien;
    logic flag;
    logic irq;
    logic ack;
    logic [31:0] rdata;
    logic [3:0] inhibit;
    logic pend;
    logic [1:0] pend_dly;
    logic samp;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic wdt_out;
  } tcsp_state_t;

  localparam logic [3:0] INHIBIT_INIT = 4'(tcsp_pkg::WRITE_INHIBIT_CLKS);
  localparam logic [1:0] PEND_INIT = 2'(tcsp_pkg::ROLLOVER_DELAY_CLKS - 2);

  tcsp_state_t st;
  tcsp_state_t next_st;
  tcsp_psc_if psc ();

  logic access;
  logic cw;
  logic ow;
  logic iw;
  logic css;
  logic ses;
  logic prescaler_assign;
  logic run;
  logic instr_tick;
  logic sample_ph;
  logic pin_lvl;
  logic pin_edge;
  logic src_lvl;
  logic ext_evt;
  logic timer_evt;
  logic inc_evt;

  function automatic logic reg_write(input logic acc, input logic ack, input logic we, input logic sel0,
                                     input logic [3:0] adr, input logic [3:0] off);
    reg_write = acc && ack && we && sel0 && (adr == off);
  endfunction

  tcsp_prescaler u_psc (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .bus(psc)
  );

  always_comb begin
    next_st = st;
    access = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master sees ack
    cw = reg_write(access, st.ack, wb_we_i, wb_sel_i[0], wb_adr_i, tcsp_pkg::OFF_COUNT);
    ow = reg_write(access, st.ack, wb_we_i, wb_sel_i[0], wb_adr_i, tcsp_pkg::OFF_OPTION);
    iw = reg_write(access, st.ack, wb_we_i, wb_sel_i[0], wb_adr_i, tcsp_pkg::OFF_INTCTL);
    css = st.option[tcsp_pkg::OPT_CSS_BIT];
    ses = st.option[tcsp_pkg::OPT_SES_BIT];
    prescaler_assign = st.option[tcsp_pkg::OPT_PSA_BIT];
    run = !sleep_i;
    next_st.phase = st.phase + 2'h1;
    instr_tick = st.phase == tcsp_pkg::PH_Q4;
    sample_ph = (st.phase == tcsp_pkg::PH_Q2) || (st.phase == tcsp_pkg::PH_Q4);

    next_st.ack = access && !st.ack;
    if (access && !st.ack) begin
      case (wb_adr_i)
        tcsp_pkg::OFF_COUNT: next_st.rdata = {24'h000000, st.count};
        tcsp_pkg::OFF_OPTION: next_st.rdata = {26'h0000000, st.option};
        tcsp_pkg::OFF_INTCTL: next_st.rdata = {24'h000000, 2'h0, st.ien, 2'h0, st.flag, 2'h0};
        // Prescaler count is deliberately not mapped
        default: next_st.rdata = 32'h00000000;
      endcase
    end

    // Pin passes two flip-flops before anything looks at it
    next_st.pin_s1 = ext_count_input_i;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_prev = st.pin_s2;
    pin_lvl = st.pin_s2 ^ ses;
    pin_edge = pin_lvl && !(st.pin_prev ^ ses);

    // One prescaler only; its input follows the assign bit
    psc.ce = ce_i;
    psc.ratio = st.option[tcsp_pkg::OPT_RATIO_LSB +: 3];
    if (prescaler_assign) begin
      psc.tick = wdt_tick_i;
    end else begin
      psc.tick = run && (css ? pin_edge : instr_tick);
    end
    psc.clear = (cw && !prescaler_assign) || (wdt_clear_i && prescaler_assign);

    // External path: raw level or divided level, sampled on Q2 and Q4
    src_lvl = prescaler_assign ? pin_lvl : psc.level;
    if (sample_ph) begin
      next_st.samp = src_lvl;
    end
    ext_evt = sample_ph && src_lvl && !st.samp;
    timer_evt = prescaler_assign ? instr_tick : psc.rise;
    inc_evt = run && (st.inhibit == 4'h0) && (css ? ext_evt : timer_evt);

    if (st.inhibit != 4'h0) begin
      next_st.inhibit = st.inhibit - 4'h1;
    end
    // Increments retire a fixed delay after the synchronised edge
    if (st.pend) begin
      if (st.pend_dly == 2'h0) begin
        next_st.count = st.count + 8'h01;
        next_st.pend = 1'b0;
      end else begin
        next_st.pend_dly = st.pend_dly - 2'h1;
      end
    end
    if (inc_evt) begin
      next_st.pend = 1'b1;
      next_st.pend_dly = PEND_INIT;
    end

    if (ow) begin
      next_st.option = wb_dat_i[tcsp_pkg::OPT_W-1:0];
    end
    if (cw) begin
      next_st.count = wb_dat_i[7:0];
      next_st.pend = 1'b0;
      next_st.inhibit = INHIBIT_INIT;
    end
    if (iw) begin
      next_st.ien = wb_dat_i[tcsp_pkg::ICR_IEN_BIT];
      next_st.flag = wb_dat_i[tcsp_pkg::ICR_FLAG_BIT];
    end
    // Flag sets with the increment event at 0xff, two clocks before the count wraps; a set in the clearing cycle wins
    if (inc_evt && (st.count == 8'hff)) begin
      next_st.flag = 1'b1;
    end
    next_st.irq = next_st.flag && next_st.ien;
    next_st.wdt_out = prescaler_assign ? psc.rise : wdt_tick_i;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st.phase <= 2'h0;
      st.count <= tcsp_pkg::RST_COUNT;
      st.option <= tcsp_pkg::RST_OPTION;
      st.ien <= tcsp_pkg::RST_IEN;
      st.flag <= tcsp_pkg::RST_FLAG;
      st.irq <= 1'b0;
      st.ack <= 1'b0;
      st.rdata <= 32'h00000000;
      st.inhibit <= 4'h0;
      st.pend <= 1'b0;
      st.pend_dly <= 2'h0;
      // Idle-low pin seen through the reset edge select reads high; match it so reset makes no false edge
      st.samp <= tcsp_pkg::RST_OPTION[tcsp_pkg::OPT_SES_BIT];
      st.pin_s1 <= 1'b0;
      st.pin_s2 <= 1'b0;
      st.pin_prev <= 1'b0;
      st.wdt_out <= 1'b0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign overflow_irq_o = st.irq;
  assign wdt_tick_o = st.wdt_out;

  // Checks; a low clock enable aborts them since all state freezes
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i || !ce_i);

  property p_flag_on_wrap;
    inc_evt && (st.count == 8'hff) |=> st.flag;
  endproperty
  a_flag_on_wrap: assert property (p_flag_on_wrap) else $error("flag not set on wrap");

  property p_rollover_delay;
    (inc_evt && !cw) ##1 (!cw && ce_i) [*2] |=> st.count == $past(st.count, 3) + 8'h01;
  endproperty
  a_rollover_delay: assert property (p_rollover_delay) else $error("count not updated 3 clocks later");

  property p_write_inhibit;
    cw |=> (!inc_evt) [*8];
  endproperty
  a_write_inhibit: assert property (p_write_inhibit) else $error("increment inside write inhibit");

  property p_irq_masked;
    overflow_irq_o == (st.flag && st.ien);
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq without flag and enable");

  property p_psc_clear_write;
    cw && !prescaler_assign |=> psc.count == 8'h00;
  endproperty
  a_psc_clear_write: assert property (p_psc_clear_write) else $error("prescaler not cleared by write");

  property p_psc_clear_wdt;
    wdt_clear_i && prescaler_assign |=> psc.count == 8'h00;
  endproperty
  a_psc_clear_wdt: assert property (p_psc_clear_wdt) else $error("prescaler not cleared by watchdog clear");

  property p_sleep_stops;
    sleep_i |-> !inc_evt;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops) else $error("timer counted in sleep");

  property p_timer_each_instr;
    !css && prescaler_assign && !sleep_i && (st.inhibit == 4'h0) && instr_tick |-> inc_evt;
  endproperty
  a_timer_each_instr: assert property (p_timer_each_instr) else $error("missed instruction-cycle increment");

  property p_ratio_min_spacing;
    inc_evt && !css && !prescaler_assign && (psc.ratio == 3'h0) |=> (!inc_evt) [*7];
  endproperty
  a_ratio_min_spacing: assert property (p_ratio_min_spacing) else $error("1:2 ratio counted too fast");

  property p_psc_owner;
    prescaler_assign && !wdt_tick_i |-> !psc.tick;
  endproperty
  a_psc_owner: assert property (p_psc_owner) else $error("prescaler fed by timer while on watchdog");

  property p_flag_sticky;
    st.flag && !iw |=> st.flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared without a software write");

  property p_masked_wrap;
    inc_evt && (st.count == 8'hff) && !st.ien && !iw |=> st.flag && !overflow_irq_o;
  endproperty
  a_masked_wrap: assert property (p_masked_wrap) else $error("masked wrap lost flag or raised irq");

  property p_sleep_holds;
    sleep_i && !st.pend && !cw |=> $stable(st.count);
  endproperty
  a_sleep_holds: assert property (p_sleep_holds) else $error("count moved during sleep");

  property p_timer_gap;
    inc_evt && !css && prescaler_assign |=> (!inc_evt) [*3];
  endproperty
  a_timer_gap: assert property (p_timer_gap) else $error("timer counted faster than once per instruction");

  property p_psc_idle_on_wdt;
    prescaler_assign && !wdt_tick_i && !wdt_clear_i |=> $stable(psc.count);
  endproperty
  a_psc_idle_on_wdt: assert property (p_psc_idle_on_wdt) else $error("prescaler moved without watchdog tick");

  c_wrap: cover property (inc_evt && st.count == 8'hff);
  c_count_write: cover property (cw ##9 inc_evt);
  c_ext_count: cover property (css && ext_evt);
  c_wdt_tick: cover property (prescaler_assign && psc.rise);
  c_masked_wrap: cover property (inc_evt && st.count == 8'hff && !st.ien);
endmodule

// ==== testbench/tcsp_far_side.sv ====
// Far-side model: external count pin source and watchdog tick and clear pulses.
// Assumes it shares clock_i with the timer; tasks are entered just after a rising edge.
`timescale 1ns/1ps
module tcsp_far_side (
  input wire logic clock_i,
  output logic pin_o,
  output logic tick_o,
  output logic clr_o
);
  initial begin
    pin_o = 1'b0;
    tick_o = 1'b0;
    clr_o = 1'b0;
  end
  // Four clocks high and low, twice what the synchroniser needs
  task automatic pulses(input int n, input logic last);
    for (int i = 0; i < n; i++) begin
      pin_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      pin_o <= 1'b0;
      repeat (4) @(posedge clock_i);
    end
    pin_o <= last;
  endtask
  task automatic ticks(input int n);
    for (int i = 0; i < n; i++) begin
      tick_o <= 1'b1;
      @(posedge clock_i);
      tick_o <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
  endtask
  task automatic wdt_clear();
    clr_o <= 1'b1;
    @(posedge clock_i);
    clr_o <= 1'b0;
    @(posedge clock_i);
  endtask
endmodule

// ==== testbench/tcsp_top_bench.sv ====
// Self-checking bench: registers over classic Wishbone, far-side model for pin and watchdog.
// Assumes a 40 ns clock and the register map held in tcsp_pkg.
`timescale 1ns/1ps
module tcsp_top_bench;
  localparam logic [3:0] a_cnt = tcsp_pkg::OFF_COUNT;
  localparam logic [3:0] a_opt = tcsp_pkg::OFF_OPTION;
  localparam logic [3:0] a_ict = tcsp_pkg::OFF_INTCTL;
  logic clock_i, nrst_i, ce, cyc, stb, we, ack, pin, sleep, tick, clr, tick_o, irq;
  logic [3:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0] q;
  int failures = 0;
  int compares = 0;
  int seen = 0;

  tcsp_top u_tcsp_top (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_count_input_i(pin), .sleep_i(sleep), .wdt_tick_i(tick), .wdt_clear_i(clr),
    .wdt_tick_o(tick_o), .overflow_irq_o(irq));
  tcsp_far_side u_tcsp_far_side (.clock_i(clock_i), .pin_o(pin), .tick_o(tick), .clr_o(clr));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) if (tick_o === 1'b1) seen <= seen + 1;

  task automatic results();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("Error at %0t: got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  // Request stands until the rising edge that samples ack high; read data is taken at that edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      $display("Error at %0t: no ack", $time);
      results();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock_i);
  endtask

  initial begin
    nrst_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    sleep = 1'b0;
    ce = 1'b1;
    repeat (5) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    wb(1'b0, a_cnt, 8'h00);
    chk(q, tcsp_pkg::RST_COUNT);
    wb(1'b0, a_opt, 8'h00);
    chk(q, 8'h3f);
    wb(1'b0, a_ict, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, 4'hc, 8'h00);
    chk(q, 8'h00);
    $display("test reset done");
    wb(1'b1, a_opt, 8'h08);
    wb(1'b1, a_cnt, 8'h00);
    repeat (100) @(posedge clock_i);
    wb(1'b0, a_cnt, 8'h00);
    chk_rng(q, 8'h15, 8'h18);
    $display("test timer rate done");
    wb(1'b1, a_ict, 8'h00);
    wb(1'b1, a_cnt, 8'hfd);
    q = 8'h00;
    for (int i = 0; i < 40 && q[2] !== 1'b1; i++) wb(1'b0, a_ict, 8'h00);
    chk(q, 8'h04);
    chk({7'h0, irq}, 8'h00);
    wb(1'b0, a_cnt, 8'h00);
    chk_rng(q, 8'h00, 8'h01);
    wb(1'b1, a_ict, 8'h24);
    @(posedge clock_i);
    chk({7'h0, irq}, 8'h01);
    wb(1'b1, a_ict, 8'h20);
    @(posedge clock_i);
    chk({7'h0, irq}, 8'h00);
    $display("test overflow done");
    // Four increments per ratio; a wrong divisor lands far outside 3..4
    for (int n = 0; n < 8; n++) begin
      // A count write first holds off increments while the ratio changes
      wb(1'b1, a_cnt, 8'h00);
      wb(1'b1, a_opt, {5'h00, 3'(n)});
      wb(1'b1, a_cnt, 8'h00);
      repeat (32 << n) @(posedge clock_i);
      wb(1'b0, a_cnt, 8'h00);
      chk_rng(q, 8'h03, 8'h04);
    end
    $display("test ratios done");
    // Three pulses then a rise left standing: rising edges give 4, falling 3, /2 gives 2
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, a_opt, k == 0 ? 8'h28 : k == 1 ? 8'h38 : 8'h20);
      wb(1'b1, a_cnt, 8'h00);
      repeat (12) @(posedge clock_i);
      u_tcsp_far_side.pulses(3, 1'b1);
      repeat (20) @(posedge clock_i);
      wb(1'b0, a_cnt, 8'h00);
      chk(q, k == 0 ? 8'h04 : k == 1 ? 8'h03 : 8'h02);
      u_tcsp_far_side.pulses(0, 1'b0);
      repeat (20) @(posedge clock_i);
    end
    $display("test counter mode done");
    sleep <= 1'b1;
    wb(1'b1, a_opt, 8'h00);
    wb(1'b1, a_cnt, 8'h55);
    repeat (50) @(posedge clock_i);
    // Awake but frozen by the clock enable: the count must still hold
    sleep <= 1'b0;
    ce <= 1'b0;
    repeat (50) @(posedge clock_i);
    ce <= 1'b1;
    wb(1'b0, a_cnt, 8'h00);
    chk(q, 8'h55);
    $display("test sleep done");
    wb(1'b1, a_cnt, 8'h00);
    u_tcsp_far_side.wdt_clear();
    wb(1'b1, a_opt, 8'h09);
    seen = 0;
    u_tcsp_far_side.ticks(8);
    repeat (4) @(posedge clock_i);
    chk_rng(8'(seen), 8'h02, 8'h04);
    u_tcsp_far_side.wdt_clear();
    wb(1'b1, a_opt, 8'h00);
    seen = 0;
    u_tcsp_far_side.ticks(8);
    repeat (4) @(posedge clock_i);
    chk(8'(seen), 8'h08);
    $display("test watchdog share done");
    results();
  end
endmodule
